/* common/cca_cfg.svh */
// constants of the capture/compare array unit
`ifndef CCA_CFG_SVH
`define CCA_CFG_SVH
`define CCA_N          16
`define CCA_W          16
`define CCA_PAIRS      8
`define CCA_PSC_W      7
`define CCA_STAG_MASK  7'h07
`define CCA_PSC_ONE    8'h01
`define CCA_CNT_MAX    16'hFFFF
`define CCA_CNT_RST    16'h0000
`define CCA_SYNC_W     17
`define CCA_EXT_BIT    16
`endif

/* common/cca_pkg.sv */
// types of the capture/compare array unit
package cca_pkg;
   typedef enum logic [1:0] {
      CCA_CM_INT_MULTI = 2'h0,
      CCA_CM_TOGGLE    = 2'h1,
      CCA_CM_INT_ONCE  = 2'h2,
      CCA_CM_SET_CLR   = 2'h3
   } cca_cmode_t;
   typedef enum logic [1:0] {
      CCA_EDGE_OFF  = 2'h0,
      CCA_EDGE_RISE = 2'h1,
      CCA_EDGE_FALL = 2'h2,
      CCA_EDGE_BOTH = 2'h3
   } cca_edge_t;
   typedef enum logic [1:0] {
      CCA_SRC_PSC = 2'h0,
      CCA_SRC_AUX = 2'h1,
      CCA_SRC_EXT = 2'h2
   } cca_src_t;
endpackage : cca_pkg

/* common/cca_tb_if.sv */
// time base state carried to the register array
`timescale 1ns/100ps
`default_nettype none
`include "cca_cfg.svh"
interface cca_tb_if;
   logic [`CCA_W-1:0] cnt;
   logic              upd;
   logic              ovf;
   modport prod (output cnt, output upd, output ovf);
   modport cons (input cnt, input upd, input ovf);
endinterface : cca_tb_if
`default_nettype wire

/* verilog/cca_pin_sync.sv */
// two-flop synchroniser for the pins and the count input
`timescale 1ns/100ps
`default_nettype none
`include "cca_cfg.svh"
module cca_pin_sync (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [`CCA_SYNC_W-1:0] d,
   output logic      [`CCA_SYNC_W-1:0] q
);
   logic [`CCA_SYNC_W-1:0] s1_reg;
   logic [`CCA_SYNC_W-1:0] s1_next;
   logic [`CCA_SYNC_W-1:0] s2_reg;
   logic [`CCA_SYNC_W-1:0] s2_next;

   always_comb begin
      s1_next = d;
      s2_next = s1_reg;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end

   assign q = s2_reg;
endmodule : cca_pin_sync
`default_nettype wire

/* verilog/cca_time_base.sv */
// one reloadable 16-bit time base with clock source choice
`timescale 1ns/100ps
`default_nettype none
`include "cca_cfg.svh"
module cca_time_base #(
   parameter bit ALLOW_EXT = 1'b0
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              run,
   input  wire logic              stagger,
   input  wire logic [2:0]        psc_sel,
   input  wire cca_pkg::cca_src_t tb_src,
   input  wire logic              aux_ovf,
   input  wire logic              ext_tick,
   input  wire logic [`CCA_W-1:0] reload,
   cca_tb_if.prod                 tb
);
   import cca_pkg::*;

   logic [`CCA_PSC_W-1:0] psc_reg;
   logic [`CCA_PSC_W-1:0] psc_next;
   logic [`CCA_W-1:0]     cnt_reg;
   logic [`CCA_W-1:0]     cnt_next;
   logic                  upd_reg;
   logic                  upd_next;
   logic                  ovf_reg;
   logic                  ovf_next;
   logic                  tick;

   function automatic logic [`CCA_PSC_W-1:0] psc_mask(input logic [2:0] sel,
                                                      input logic       stag);
      logic [`CCA_PSC_W-1:0] m;
      m = `CCA_PSC_W'((`CCA_PSC_ONE << sel) - `CCA_PSC_ONE);
      if (stag) begin
         m = m | `CCA_STAG_MASK;
      end
      return m;
   endfunction : psc_mask

   // ----------------------------------------
   // prescaler, source choice, count, reload
   // ----------------------------------------
   always_comb begin
      psc_next = run ? `CCA_PSC_W'(psc_reg + 1'b1) : psc_reg;
      case (tb_src)
         CCA_SRC_PSC: tick = (psc_reg & psc_mask(psc_sel, stagger))
                             == psc_mask(psc_sel, stagger);
         CCA_SRC_AUX: tick = aux_ovf;
         CCA_SRC_EXT: tick = ALLOW_EXT & ext_tick;
         default:     tick = 1'b0;
      endcase
      tick     = tick & run;
      upd_next = tick;
      ovf_next = tick && (cnt_reg == `CCA_CNT_MAX);
      cnt_next = cnt_reg;
      if (ovf_next) begin
         cnt_next = reload;
      end else if (tick) begin
         cnt_next = `CCA_W'(cnt_reg + 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         psc_reg <= '0;
         cnt_reg <= `CCA_CNT_RST;
         upd_reg <= 1'b0;
         ovf_reg <= 1'b0;
      end else begin
         psc_reg <= psc_next;
         cnt_reg <= cnt_next;
         upd_reg <= upd_next;
         ovf_reg <= ovf_next;
      end
   end

   assign tb.cnt = cnt_reg;
   assign tb.upd = upd_reg;
   assign tb.ovf = ovf_reg;

   a_tb_reload: assert property (@(posedge clk) disable iff (!rst_n)
      ovf_reg |-> cnt_reg == $past(reload))
      else $error("time base did not reload on overflow");
   a_stag_res: assert property (@(posedge clk) disable iff (!rst_n)
      (upd_reg && stagger && tb_src == CCA_SRC_PSC)
      |=> (!(upd_reg && stagger && tb_src == CCA_SRC_PSC))[*7])
      else $error("staggered step closer than eight cycles");
endmodule : cca_time_base
`default_nettype wire

/* verilog/cca_unit.sv */
// sixteen-channel capture/compare array with two time bases
`timescale 1ns/100ps
`default_nettype none
`include "cca_cfg.svh"
module cca_unit (
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   input  wire logic [`CCA_N-1:0]                   cc_pin_in,
   input  wire logic                                ext_count_in,
   input  wire logic                                aux_ovf,
   input  wire logic                                stagger_en,
   input  wire logic                                tba_run,
   input  wire logic                                tbb_run,
   input  wire cca_pkg::cca_src_t                   tba_src,
   input  wire cca_pkg::cca_src_t                   tbb_src,
   input  wire logic [2:0]                          tba_psc,
   input  wire logic [2:0]                          tbb_psc,
   input  wire logic [`CCA_W-1:0]                   tba_reload,
   input  wire logic [`CCA_W-1:0]                   tbb_reload,
   input  wire logic                                tba_ovf_clr,
   input  wire logic                                tbb_ovf_clr,
   input  wire logic [`CCA_N-1:0]                   ch_use_b,
   input  wire logic [`CCA_N-1:0]                   ch_capture,
   input  wire cca_pkg::cca_cmode_t [`CCA_N-1:0]    ch_mode,
   input  wire cca_pkg::cca_edge_t  [`CCA_N-1:0]    ch_edge,
   input  wire logic [`CCA_N-1:0]                   ch_single,
   input  wire logic [`CCA_PAIRS-1:0]               pair_en,
   input  wire logic                                cc_wr_en,
   input  wire logic [3:0]                          cc_wr_idx,
   input  wire logic [`CCA_W-1:0]                   cc_wr_data,
   input  wire logic [3:0]                          cc_rd_idx,
   output logic      [`CCA_W-1:0]                   cc_rd_data,
   output logic      [`CCA_N-1:0]                   cc_pin_out,
   output logic      [`CCA_N-1:0]                   cc_pin_oe,
   output logic      [`CCA_N-1:0]                   cc_irq,
   output logic      [`CCA_W-1:0]                   tba_count,
   output logic      [`CCA_W-1:0]                   tbb_count,
   output logic                                     tba_ovf_flag,
   output logic                                     tbb_ovf_flag
);
   import cca_pkg::*;

   logic [`CCA_SYNC_W-1:0] pin_s;
   logic [`CCA_W-1:0]      cc_reg   [`CCA_N];
   logic [`CCA_W-1:0]      cc_next  [`CCA_N];
   logic [`CCA_N-1:0]      prev_reg;
   logic [`CCA_N-1:0]      prev_next;
   logic [`CCA_N-1:0]      pin_reg;
   logic [`CCA_N-1:0]      pin_next;
   logic [`CCA_N-1:0]      oe_reg;
   logic [`CCA_N-1:0]      oe_next;
   logic [`CCA_N-1:0]      irq_reg;
   logic [`CCA_N-1:0]      irq_next;
   logic [`CCA_N-1:0]      done_reg;
   logic [`CCA_N-1:0]      done_next;
   logic [`CCA_N-1:0]      hit_reg;
   logic [`CCA_N-1:0]      hit_next;
   logic [`CCA_N-1:0]      act_v;
   logic [`CCA_W-1:0]      rd_reg;
   logic [`CCA_W-1:0]      rd_next;
   logic                   fa_reg;
   logic                   fa_next;
   logic                   fb_reg;
   logic                   fb_next;
   logic                   ext_prev_reg;
   logic                   ext_prev_next;
   logic                   ext_tick;

   cca_tb_if tba ();
   cca_tb_if tbb ();

   function automatic logic cap_fire(input cca_edge_t e,
                                     input logic      p,
                                     input logic      n);
      logic r;
      case (e)
         CCA_EDGE_RISE: r = !p && n;
         CCA_EDGE_FALL: r = p && !n;
         CCA_EDGE_BOTH: r = p != n;
         default:       r = 1'b0;
      endcase
      return r;
   endfunction : cap_fire

   // ----------------------------------------
   // pin synchronisers and time bases
   // ----------------------------------------
   cca_pin_sync u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({ext_count_in, cc_pin_in}),
      .q     (pin_s)
   );

   assign ext_tick = pin_s[`CCA_EXT_BIT] & ~ext_prev_reg;

   cca_time_base #(.ALLOW_EXT(1'b1)) u_tba (
      .clk      (clk),
      .rst_n    (rst_n),
      .run      (tba_run),
      .stagger  (stagger_en),
      .psc_sel  (tba_psc),
      .tb_src   (tba_src),
      .aux_ovf  (aux_ovf),
      .ext_tick (ext_tick),
      .reload   (tba_reload),
      .tb       (tba)
   );

   cca_time_base #(.ALLOW_EXT(1'b0)) u_tbb (
      .clk      (clk),
      .rst_n    (rst_n),
      .run      (tbb_run),
      .stagger  (stagger_en),
      .psc_sel  (tbb_psc),
      .tb_src   (tbb_src),
      .aux_ovf  (aux_ovf),
      .ext_tick (1'b0),
      .reload   (tbb_reload),
      .tb       (tbb)
   );

   // ----------------------------------------
   // channel capture and compare
   // ----------------------------------------
   always_comb begin
      logic [`CCA_W-1:0] cnt_i;
      logic              upd_i;
      logic              ovf_i;
      logic              hit_i;
      logic              once;
      cnt_i     = '0;
      upd_i     = 1'b0;
      ovf_i     = 1'b0;
      hit_i     = 1'b0;
      once      = 1'b0;
      cc_next   = cc_reg;
      pin_next  = pin_reg;
      oe_next   = '0;
      irq_next  = '0;
      done_next = done_reg;
      hit_next  = hit_reg;
      act_v     = '0;
      prev_next = pin_s[`CCA_N-1:0];
      if (cc_wr_en) begin
         cc_next[cc_wr_idx]   = cc_wr_data;
         done_next[cc_wr_idx] = 1'b0;
      end
      for (int i = 0; i < `CCA_N; i++) begin
         cnt_i = ch_use_b[i] ? tbb.cnt : tba.cnt;
         upd_i = ch_use_b[i] ? tbb.upd : tba.upd;
         ovf_i = ch_use_b[i] ? tbb.ovf : tba.ovf;
         if (ovf_i) begin
            hit_next[i] = 1'b0;
         end
         if (ch_capture[i]) begin
            if (cap_fire(ch_edge[i], prev_reg[i], pin_s[i])) begin
               cc_next[i]  = cnt_i;
               irq_next[i] = 1'b1;
            end
         end else begin
            hit_i = upd_i && (cnt_i == cc_reg[i]);
            once  = (ch_mode[i] == CCA_CM_INT_ONCE) ||
                    (ch_mode[i] == CCA_CM_SET_CLR);
            act_v[i] = hit_i && !(ch_single[i] && done_reg[i])
                       && !(once && hit_reg[i] && !ovf_i);
            if (act_v[i]) begin
               irq_next[i] = 1'b1;
               hit_next[i] = 1'b1;
               if (ch_single[i]) begin
                  done_next[i] = 1'b1;
               end
            end
            case (ch_mode[i])
               CCA_CM_TOGGLE: begin
                  oe_next[i] = 1'b1;
                  if (act_v[i]) begin
                     pin_next[i] = ~pin_reg[i];
                  end
               end
               CCA_CM_SET_CLR: begin
                  oe_next[i] = 1'b1;
                  if (act_v[i]) begin
                     pin_next[i] = 1'b1;
                  end else if (ovf_i) begin
                     pin_next[i] = 1'b0;
                  end
               end
               default: oe_next[i] = 1'b0;
            endcase
         end
      end
      for (int p = 0; p < `CCA_PAIRS; p++) begin
         if (pair_en[p]) begin
            oe_next[p]              = 1'b1;
            oe_next[p+`CCA_PAIRS]   = 1'b0;
            pin_next[p+`CCA_PAIRS]  = pin_reg[p+`CCA_PAIRS];
            pin_next[p] = pin_reg[p] ^ (act_v[p] | act_v[p+`CCA_PAIRS]);
         end
      end
   end

   // ----------------------------------------
   // flags, readback and edge memory
   // ----------------------------------------
   always_comb begin
      fa_next       = tba.ovf | (fa_reg & ~tba_ovf_clr);
      fb_next       = tbb.ovf | (fb_reg & ~tbb_ovf_clr);
      rd_next       = cc_reg[cc_rd_idx];
      ext_prev_next = pin_s[`CCA_EXT_BIT];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `CCA_N; i++) begin
            cc_reg[i] <= '0;
         end
         prev_reg     <= '0;
         pin_reg      <= '0;
         oe_reg       <= '0;
         irq_reg      <= '0;
         done_reg     <= '0;
         hit_reg      <= '0;
         rd_reg       <= '0;
         fa_reg       <= 1'b0;
         fb_reg       <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         cc_reg       <= cc_next;
         prev_reg     <= prev_next;
         pin_reg      <= pin_next;
         oe_reg       <= oe_next;
         irq_reg      <= irq_next;
         done_reg     <= done_next;
         hit_reg      <= hit_next;
         rd_reg       <= rd_next;
         fa_reg       <= fa_next;
         fb_reg       <= fb_next;
         ext_prev_reg <= ext_prev_next;
      end
   end

   assign cc_rd_data   = rd_reg;
   assign cc_pin_out   = pin_reg;
   assign cc_pin_oe    = oe_reg;
   assign cc_irq       = irq_reg;
   assign tba_count    = tba.cnt;
   assign tbb_count    = tbb.cnt;
   assign tba_ovf_flag = fa_reg;
   assign tbb_ovf_flag = fb_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_ovf_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (tba.ovf || tbb.ovf) |=> (tba_ovf_flag || !$past(tba.ovf))
                               && (tbb_ovf_flag || !$past(tbb.ovf)))
      else $error("overflow flag not set");

   for (genvar g = 0; g < `CCA_N; g++) begin : g_chk
      logic [`CCA_W-1:0] cnt_w;
      logic              cap_w;
      logic              paired_w;
      logic              ovf_w;
      assign cnt_w    = ch_use_b[g] ? tbb.cnt : tba.cnt;
      assign cap_w    = ch_capture[g] && cap_fire(ch_edge[g], prev_reg[g], pin_s[g]);
      assign paired_w = pair_en[g % `CCA_PAIRS];
      assign ovf_w    = ch_use_b[g] ? tbb.ovf : tba.ovf;

      a_cap_latch: assert property (@(posedge clk) disable iff (!rst_n)
         cap_w |=> cc_reg[g] == $past(cnt_w))
         else $error("capture did not latch the time base");
      a_cap_irq: assert property (@(posedge clk) disable iff (!rst_n)
         cap_w |=> cc_irq[g])
         else $error("capture raised no interrupt");
      a_mode0_pin: assert property (@(posedge clk) disable iff (!rst_n)
         (!ch_capture[g] && ch_mode[g] == CCA_CM_INT_MULTI && !paired_w)
         |=> !cc_pin_oe[g])
         else $error("interrupt-only mode drove its pin");
      a_toggle_pin: assert property (@(posedge clk) disable iff (!rst_n)
         (act_v[g] && ch_mode[g] == CCA_CM_TOGGLE && !paired_w)
         |=> cc_pin_out[g] != $past(cc_pin_out[g]))
         else $error("toggle mode match did not flip pin");
      a_mode3_set: assert property (@(posedge clk) disable iff (!rst_n)
         (act_v[g] && ch_mode[g] == CCA_CM_SET_CLR && !paired_w)
         |=> cc_pin_out[g] && cc_irq[g])
         else $error("set mode match did not raise pin");
      a_once_period: assert property (@(posedge clk) disable iff (!rst_n)
         (cc_irq[g] && !$past(ch_capture[g]) && $past(ch_mode[g]) == CCA_CM_INT_ONCE)
         |-> !$past(hit_reg[g] && !ovf_w))
         else $error("second interrupt in one period");
      a_single_once: assert property (@(posedge clk) disable iff (!rst_n)
         (ch_single[g] && done_reg[g] && !ch_capture[g]) |=> !cc_irq[g])
         else $error("single event fired twice");
      if (g < `CCA_PAIRS) begin : g_pair
         a_pair_toggle: assert property (@(posedge clk) disable iff (!rst_n)
            (pair_en[g] && (act_v[g] || act_v[g+`CCA_PAIRS]))
            |=> cc_pin_out[g] != $past(cc_pin_out[g]))
            else $error("paired match did not toggle shared pin");
      end
   end
endmodule : cca_unit
`default_nettype wire

/* sim/cca_far_side.sv */
// far-side model: port pins, external count input, aux timer pulses
`timescale 1ns/100ps
`default_nettype none
module cca_far_side (
   input  wire logic        clk,
   output logic      [15:0] pin_drv,
   output logic             ext_count_in,
   output logic             aux_ovf
);
   initial begin
      pin_drv      = 16'h0000;
      ext_count_in = 1'b0;
      aux_ovf      = 1'b0;
   end
   // one-cycle overflow pulses of the neighbouring timer, one idle cycle between
   task automatic aux_pulses(input int n);
      repeat (n) begin
         @(posedge clk) #1 aux_ovf = 1'b1;
         @(posedge clk) #1 aux_ovf = 1'b0;
      end
   endtask : aux_pulses
   // slow pulses on the count pin, four cycles high, five cycles low between pulses
   task automatic ext_edges(input int n);
      repeat (n) begin
         @(posedge clk) #1 ext_count_in = 1'b1;
         repeat (4) @(posedge clk);
         #1 ext_count_in = 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : ext_edges
   // drive the masked pins to one level
   task automatic set_pins(input logic [15:0] m, input logic lv);
      @(posedge clk) #1 pin_drv = lv ? (pin_drv | m) : (pin_drv & ~m);
   endtask : set_pins
endmodule : cca_far_side
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench of the capture/compare array unit
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cca_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clk, rst_n, stagger_en, tba_run, tbb_run, tba_ovf_clr, tbb_ovf_clr, cc_wr_en;
   cca_src_t          tba_src, tbb_src;
   logic [2:0]        tba_psc, tbb_psc;
   logic [15:0]       tba_reload, tbb_reload, ch_use_b, ch_capture, ch_single, cc_wr_data;
   cca_cmode_t [15:0] ch_mode;
   cca_edge_t  [15:0] ch_edge;
   logic [7:0]        pair_en;
   logic [3:0]        cc_wr_idx, cc_rd_idx;
   wire logic [15:0]  cc_rd_data, cc_pin_out, cc_pin_oe, cc_irq, tba_count, tbb_count;
   wire logic [15:0]  pin_drv, cc_pin_in;
   wire logic         tba_ovf_flag, tbb_ovf_flag, ext_count_in, aux_ovf;
   int                failures, tests_run, k, irqc[16], togc[16];
   logic [15:0]       v, prev;
   // pin level: the unit where it drives, else the far side
   assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & pin_drv);
   cca_unit dut (.clk, .rst_n, .cc_pin_in, .ext_count_in, .aux_ovf, .stagger_en, .tba_run,
      .tbb_run, .tba_src, .tbb_src, .tba_psc, .tbb_psc, .tba_reload, .tbb_reload,
      .tba_ovf_clr, .tbb_ovf_clr, .ch_use_b, .ch_capture, .ch_mode, .ch_edge, .ch_single,
      .pair_en, .cc_wr_en, .cc_wr_idx, .cc_wr_data, .cc_rd_idx, .cc_rd_data, .cc_pin_out,
      .cc_pin_oe, .cc_irq, .tba_count, .tbb_count, .tba_ovf_flag, .tbb_ovf_flag);
   cca_far_side far (.clk, .pin_drv, .ext_count_in, .aux_ovf);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ----------------------------------------
   // access and check tasks
   // ----------------------------------------
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] i, input logic [15:0] d);
      cc_wr_en = 1'b1;
      cc_wr_idx = i;
      cc_wr_data = d;
      step();
      cc_wr_en = 1'b0;
      step();
   endtask : wr
   task automatic rd(input logic [3:0] i, output logic [15:0] d);
      cc_rd_idx = i;
      step(2);
      d = cc_rd_data;
   endtask : rd
   // count irq pulses and pin changes per channel
   task automatic obs(input int n, input bit clr);
      if (clr) begin
         irqc = '{default: 0};
         togc = '{default: 0};
      end
      prev = cc_pin_out;
      repeat (n) begin
         step();
         for (int i = 0; i < 16; i++) begin
            irqc[i] += int'(cc_irq[i]);
            togc[i] += int'(cc_pin_out[i] !== prev[i]);
         end
         prev = cc_pin_out;
      end
   endtask : obs
   task automatic wrap_up();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   initial begin
      #1_000_000;
      failures++;
      wrap_up();
   end
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      {rst_n, stagger_en, tba_run, tbb_run, tba_ovf_clr, tbb_ovf_clr, cc_wr_en} = '0;
      {tba_psc, tbb_psc, tba_reload, tbb_reload, ch_use_b, ch_single, pair_en} = '0;
      {cc_wr_idx, cc_rd_idx, cc_wr_data} = '0;
      ch_capture = 16'h0F00;
      tba_src = CCA_SRC_PSC;
      tbb_src = CCA_SRC_PSC;
      for (int i = 0; i < 16; i++) begin
         ch_mode[i] = CCA_CM_INT_MULTI;
         ch_edge[i] = CCA_EDGE_OFF;
      end
      ch_edge[8] = CCA_EDGE_RISE;
      ch_edge[9] = CCA_EDGE_FALL;
      ch_edge[10] = CCA_EDGE_BOTH;
      repeat (4) @(posedge clk);
      chk(tba_count | tbb_count | cc_irq | cc_pin_oe, 16'h0000);
      #1 rst_n = 1'b1;
      step(2);
      for (int i = 0; i < 16; i++) begin
         wr(4'(i), 16'(i * 16'h1111) ^ 16'h5A3C);
         rd(4'(i), v);
         chk(v, 16'(i * 16'h1111) ^ 16'h5A3C);
      end
      tba_run = 1'b1;
      step(2);
      v = tba_count;
      step(10);
      chk(tba_count - v, 16'h000A);
      tba_psc = 3'h2;
      step(2);
      v = tba_count;
      step(40);
      chk(tba_count - v, 16'h000A);
      tba_psc = 3'h0;
      stagger_en = 1'b1;
      step(2);
      v = tba_count;
      step(80);
      chk(tba_count - v, 16'h000A);
      stagger_en = 1'b0;
      tbb_src = CCA_SRC_AUX;
      tbb_run = 1'b1;
      step(2);
      v = tbb_count;
      far.aux_pulses(5);
      step(2);
      chk(tbb_count - v, 16'h0005);
      tba_src = CCA_SRC_EXT;
      step(2);
      v = tba_count;
      far.ext_edges(3);
      step(6);
      chk(tba_count - v, 16'h0003);
      tba_reload = 16'hFFE0;
      tbb_reload = 16'hFFE0;
      tba_src = CCA_SRC_PSC;
      tbb_src = CCA_SRC_PSC;
      for (k = 0; k < 70000 && tba_ovf_flag !== 1'b1; k++) step();
      chk(16'(tba_ovf_flag), 16'h0001);
      chk(tba_count, 16'hFFE1);
      tba_ovf_clr = 1'b1;
      step();
      tba_ovf_clr = 1'b0;
      chk(16'(tba_ovf_flag), 16'h0000);
      step(31);
      chk(16'(tba_ovf_flag), 16'h0001);
      chk(tba_count, 16'hFFE1);
      for (k = 0; k < 100 && tbb_ovf_flag !== 1'b1; k++) step();
      chk(16'(tbb_ovf_flag), 16'h0001);
      tbb_run = 1'b0;
      ch_mode[1] = CCA_CM_TOGGLE;
      ch_mode[2] = CCA_CM_SET_CLR;
      ch_mode[3] = CCA_CM_TOGGLE;
      ch_mode[5] = CCA_CM_TOGGLE;
      ch_mode[13] = CCA_CM_TOGGLE;
      ch_mode[6] = CCA_CM_INT_ONCE;
      ch_mode[12] = CCA_CM_INT_ONCE;
      ch_single[3] = 1'b1;
      ch_use_b[4] = 1'b1;
      pair_en[5] = 1'b1;
      wr(4'h0, 16'hFFF0);
      wr(4'h1, 16'hFFE8);
      wr(4'h2, 16'hFFF0);
      wr(4'h4, 16'hFFE0);
      wr(4'h5, 16'hFFE4);
      wr(4'hD, 16'hFFF4);
      wr(4'h6, 16'hFFE4);
      wr(4'h7, 16'hFFE4);
      wr(4'hC, 16'hFFE0);
      step(40);
      wr(4'h3, 16'hFFEC);
      obs(64, 1'b1);
      chk(16'(irqc[0]), 16'h0002);
      chk(16'(cc_pin_oe[0]), 16'h0000);
      chk(16'(togc[1]), 16'h0002);
      chk(16'(togc[2]), 16'h0004);
      chk(16'(togc[3]), 16'h0001);
      chk(16'(irqc[4]), 16'h0000);
      chk(16'(togc[5]), 16'h0004);
      chk(16'(togc[13]) | 16'(cc_pin_oe[13]), 16'h0000);
      chk(16'(irqc[6]), 16'h0002);
      chk(16'(irqc[7]), 16'h0002);
      chk(16'(irqc[12]), 16'h0002);
      for (k = 0; k < 40 && cc_irq[7] !== 1'b1; k++) step();
      wr(4'h6, 16'hFFF4);
      wr(4'h7, 16'hFFF4);
      obs(20, 1'b1);
      chk(16'(irqc[7]), 16'h0001);
      chk(16'(irqc[6]), 16'h0000);
      obs(40, 1'b1);
      chk(16'(irqc[6]), 16'h0001);
      tba_run = 1'b0;
      step(2);
      wr(4'h8, 16'h0000);
      wr(4'h9, 16'h0000);
      irqc = '{default: 0};
      far.set_pins(16'h0F00, 1'b1);
      obs(8, 1'b0);
      far.set_pins(16'h0F00, 1'b0);
      obs(8, 1'b0);
      chk(16'(irqc[8]), 16'h0001);
      chk(16'(irqc[9]), 16'h0001);
      chk(16'(irqc[10]), 16'h0002);
      chk(16'(irqc[11]), 16'h0000);
      rd(4'h8, v);
      chk(v, tba_count);
      rd(4'h9, v);
      chk(v, tba_count);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
